// ==== src/pms_pkg.sv ====
package pms_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MDC_MIN_EDGE_NS = 160;
  localparam int MDC_MIN_EDGE_CYC = (MDC_MIN_EDGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PREAMBLE_ONES = 32;
  localparam int STRAP_SETTLE_CYC = 2;
  localparam logic [4:0] HDR_BITS = 5'h0D;
  localparam logic [4:0] RD_BITS = 5'h11;
  localparam logic [4:0] WR_BITS = 5'h12;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STAT = 5'h01;
  localparam logic [4:0] REG_ID_HI = 5'h02;
  localparam logic [4:0] REG_ID_LO = 5'h03;
  localparam logic [4:0] REG_ADV = 5'h04;
  localparam logic [4:0] REG_PARTNER = 5'h05;
  localparam logic [4:0] REG_EXPANSION = 5'h06;
  localparam logic [4:0] REG_VENDOR_MODE = 5'h11;
  localparam int VEND_SEL_BIT = 4;
  localparam int ANY_ADDR_BIT = 3;
  localparam int CB_RESET = 15;
  localparam int CB_LOOPBACK = 14;
  localparam int CB_SPEED = 13;
  localparam int CB_AN_EN = 12;
  localparam int CB_POWER_DOWN = 11;
  localparam int CB_ISOLATE = 10;
  localparam int CB_AN_RESTART = 9;
  localparam int CB_DUPLEX = 8;
  localparam int CB_COL_TEST = 7;
  localparam logic [15:0] CTRL_RESET_VAL = 16'h3000;
  localparam logic [15:0] ADV_RESET_VAL = 16'h01E1;
  localparam logic [15:0] ADV_WRITE_MASK = 16'h2FE0;
  localparam logic [15:0] STAT_ABILITY = 16'h7808;
  localparam logic [15:0] STAT_EXT_CAP = 16'h0001;
  localparam logic [15:0] UNIMPL_READ_VAL = 16'hFFFF;
  localparam logic [15:0] VENDOR_RESET_VAL = 16'h0000;
  localparam logic [4:0] ADDR_STRAP_DEFAULT = 5'h1F;

  typedef struct packed {
    logic loopback;
    logic speed_100;
    logic an_enable;
    logic power_down;
    logic isolate;
    logic full_duplex;
    logic collision_test;
  } pms_ctrl_s;

  typedef struct packed {
    logic an_complete;
    logic remote_fault;
    logic link_up;
    logic jabber;
  } pms_stat_s;

  typedef enum logic [3:0] {
    ST_PREAMBLE = 4'b0001,
    ST_HEADER = 4'b0010,
    ST_READ = 4'b0100,
    ST_WRITE = 4'b1000
  } pms_state_e;
endpackage

// ==== src/pms_regmem.sv ====
`timescale 1ns/1ps
module pms_regmem import pms_pkg::*; #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] rd_data_nxt;

  always_comb begin
    rd_data_nxt = mem_r[rd_addr];
  end

  // Reset keeps vendor registers defined; a small array, so the cost is minor
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= WIDTH'(VENDOR_RESET_VAL);
      end
      rd_data <= '0;
    end else begin
      if (wr_en) begin
        mem_r[wr_addr] <= wr_data;
      end
      rd_data <= rd_data_nxt;
    end
  end
endmodule // pms_regmem

// ==== src/pms_mgmt_port.sv ====
`timescale 1ns/1ps
// Operation
// - Strap at reset release picks interrupt output or transmit-side input for shared pin
// - Five-bit station address captured from straps at reset; floating gives all ones
// - Strap high makes its LED active low; strap low makes it active high
// - Standard registers 0 to 6 and vendor registers 16 to 31 are implemented
// - Reads of registers 7 to 15 return all ones
// - Register 17 bit 3 makes the port answer any station address
// - Data line is open drain: only pulled low or released; clock from controller
// - Data line sampled on each rising edge of management clock
// - Register 0 holds reset, loopback, speed, negotiation, power, isolate, restart, duplex
// - Register 1 reports abilities in 15:11 and negotiation and link status in 5:0
// - Register 4 holds remote fault, pause, abilities and selector; next page bit always reads zero
// - Bit 9 restarts negotiation; bit 12 clear forces speed and duplex bits
// - Advertisement writes take effect only at the next negotiation restart
module pms_mgmt_port import pms_pkg::*; #(
  parameter logic [15:0] ID_HIGH = 16'h1234,
  parameter logic [5:0] ID_LOW_OUI = 6'h15,
  parameter logic [5:0] MODEL_NUM = 6'h2A,
  parameter logic [3:0] REVISION_NUM = 4'h3,
  parameter int NUM_LEDS = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic pin_function_select_strap,
  input wire logic [4:0] station_address_strap,
  output logic [4:0] station_address,
  output logic interrupt_mode,
  input wire logic interrupt_request,
  output logic interrupt_out_n,
  output logic shared_pin_oe,
  input wire logic transmit_error_in,
  output logic transmit_side_bit,
  input wire logic [NUM_LEDS-1:0] led_state,
  output logic [NUM_LEDS-1:0] led_out,
  output pms_ctrl_s ctrl,
  output logic an_restart,
  output logic [15:0] advertised,
  input wire pms_stat_s link_stat,
  input wire logic [15:0] partner_ability,
  input wire logic [4:0] expansion
);
  // Ids above are arbitrary neutral values

  // Pin synchronisers: stage 1 is read only by stage 2
  logic [8:0] pin_s1_r, pin_s2_r, pin_s1_nxt, pin_s2_nxt;
  logic mdc_d_r, mdc_d_nxt;
  logic [1:0] settle_r, settle_nxt;
  logic strap_done_r, strap_done_nxt;
  logic [4:0] addr_r, addr_nxt;
  logic int_mode_r, int_mode_nxt;
  logic int_n_r, int_n_nxt, pin_oe_r, pin_oe_nxt, tx_bit_r, tx_bit_nxt;
  logic [NUM_LEDS-1:0] led_r, led_nxt;
  logic mdc_s, mdio_s, fsel_s, txe_s;
  logic [4:0] addr_s;
  logic mdc_rise;

  assign mdc_s = pin_s2_r[0];
  assign mdio_s = pin_s2_r[1];
  assign fsel_s = pin_s2_r[2];
  assign addr_s = pin_s2_r[7:3];
  assign txe_s = pin_s2_r[8];
  assign mdc_rise = mdc_s & ~mdc_d_r;

  always_comb begin
    pin_s1_nxt = {transmit_error_in, station_address_strap, pin_function_select_strap,
                  mdio_in, mdc};
    pin_s2_nxt = pin_s1_r;
    mdc_d_nxt = mdc_s;
    settle_nxt = settle_r;
    strap_done_nxt = strap_done_r;
    addr_nxt = addr_r;
    int_mode_nxt = int_mode_r;
    // Straps are caught once the synchroniser has filled after reset release
    if (!strap_done_r) begin
      if (settle_r == 2'(STRAP_SETTLE_CYC)) begin
        addr_nxt = addr_s;
        int_mode_nxt = fsel_s;
        strap_done_nxt = 1'b1;
      end else begin
        settle_nxt = settle_r + 2'h1;
      end
    end
    // Held off until the strap is caught, so the pin never blips low in the other mode
    int_n_nxt = ~(int_mode_r & strap_done_r & interrupt_request);
    pin_oe_nxt = int_mode_r & strap_done_r;
    tx_bit_nxt = ~int_mode_r & txe_s;
    for (int i = 0; i < NUM_LEDS; i++) begin
      led_nxt[i] = led_state[i] ^ addr_r[i];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= {1'b0, ADDR_STRAP_DEFAULT, 3'h7};
      pin_s2_r <= {1'b0, ADDR_STRAP_DEFAULT, 3'h7};
      mdc_d_r <= 1'b1;
      settle_r <= 2'h0;
      strap_done_r <= 1'b0;
      addr_r <= ADDR_STRAP_DEFAULT;
      int_mode_r <= 1'b1;
      int_n_r <= 1'b1;
      pin_oe_r <= 1'b0;
      tx_bit_r <= 1'b0;
      led_r <= '0;
    end else begin
      pin_s1_r <= pin_s1_nxt;
      pin_s2_r <= pin_s2_nxt;
      mdc_d_r <= mdc_d_nxt;
      settle_r <= settle_nxt;
      strap_done_r <= strap_done_nxt;
      addr_r <= addr_nxt;
      int_mode_r <= int_mode_nxt;
      int_n_r <= int_n_nxt;
      pin_oe_r <= pin_oe_nxt;
      tx_bit_r <= tx_bit_nxt;
      led_r <= led_nxt;
    end
  end

  assign station_address = addr_r;
  assign interrupt_mode = int_mode_r;
  assign interrupt_out_n = int_n_r;
  assign shared_pin_oe = pin_oe_r;
  assign transmit_side_bit = tx_bit_r;
  assign led_out = led_r;

  // Frame engine and registers
  pms_state_e state_r, state_nxt;
  logic [5:0] pre_cnt_r, pre_cnt_nxt;
  logic [4:0] bit_cnt_r, bit_cnt_nxt;
  logic [15:0] shift_r, shift_nxt;
  logic [4:0] reg_addr_r, reg_addr_nxt;
  logic [15:0] rd_word_r, rd_word_nxt;
  logic oe_r, oe_nxt;
  logic [15:0] ctrl_r, ctrl_nxt, adv_r, adv_nxt, adv_live_r, adv_live_nxt;
  logic restart_r, restart_nxt;
  logic any_addr_r, any_addr_nxt;
  logic mem_we;
  logic [15:0] mem_rdata;
  logic [15:0] hdr;
  logic addr_ok;
  logic [15:0] wr_word;

  assign hdr = {shift_r[14:0], mdio_s};
  assign addr_ok = any_addr_r | (hdr[9:5] == addr_r);
  assign wr_word = {shift_r[14:0], mdio_s};

  always_comb begin
    state_nxt = state_r;
    pre_cnt_nxt = pre_cnt_r;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt = shift_r;
    reg_addr_nxt = reg_addr_r;
    rd_word_nxt = rd_word_r;
    oe_nxt = oe_r;
    ctrl_nxt = ctrl_r;
    adv_nxt = adv_r;
    adv_live_nxt = adv_live_r;
    restart_nxt = 1'b0;
    any_addr_nxt = any_addr_r;
    mem_we = 1'b0;
    // Read word is assembled one rising edge before it is shifted out
    case (reg_addr_r)
      REG_CTRL: rd_word_nxt = ctrl_r;
      REG_STAT: rd_word_nxt = STAT_ABILITY | STAT_EXT_CAP |
                  {10'h000, link_stat.an_complete, link_stat.remote_fault, 1'b0,
                   link_stat.link_up, link_stat.jabber, 1'b0};
      REG_ID_HI: rd_word_nxt = ID_HIGH;
      REG_ID_LO: rd_word_nxt = {ID_LOW_OUI, MODEL_NUM, REVISION_NUM};
      REG_ADV: rd_word_nxt = adv_r;
      REG_PARTNER: rd_word_nxt = partner_ability & 16'hE7FF;
      REG_EXPANSION: rd_word_nxt = {11'h000, expansion};
      default: rd_word_nxt = reg_addr_r[VEND_SEL_BIT] ? mem_rdata : UNIMPL_READ_VAL;
    endcase
    if (mdc_rise) begin
      case (state_r)
        ST_PREAMBLE: begin
          if (mdio_s) begin
            if (pre_cnt_r != 6'(PREAMBLE_ONES)) begin
              pre_cnt_nxt = pre_cnt_r + 6'h01;
            end
          end else begin
            if (pre_cnt_r == 6'(PREAMBLE_ONES)) begin
              state_nxt = ST_HEADER;
              bit_cnt_nxt = 5'h00;
            end
            pre_cnt_nxt = 6'h00;
          end
        end
        ST_HEADER: begin
          shift_nxt = {shift_r[14:0], mdio_s};
          bit_cnt_nxt = bit_cnt_r + 5'h01;
          if (bit_cnt_r == HDR_BITS - 5'h01) begin
            bit_cnt_nxt = 5'h00;
            reg_addr_nxt = hdr[4:0];
            state_nxt = ST_PREAMBLE;
            if (hdr[12] && addr_ok) begin
              if (hdr[11:10] == OP_READ) begin
                state_nxt = ST_READ;
              end else if (hdr[11:10] == OP_WRITE) begin
                state_nxt = ST_WRITE;
              end
            end
          end
        end
        ST_READ: begin
          // First turnaround bit stays released, second is pulled low
          bit_cnt_nxt = bit_cnt_r + 5'h01;
          if (bit_cnt_r == 5'h00) begin
            oe_nxt = 1'b1;
            shift_nxt = rd_word_r;
          end else if (bit_cnt_r == RD_BITS) begin
            oe_nxt = 1'b0;
            state_nxt = ST_PREAMBLE;
          end else begin
            oe_nxt = ~shift_r[15];
            shift_nxt = {shift_r[14:0], 1'b0};
          end
        end
        ST_WRITE: begin
          shift_nxt = wr_word;
          bit_cnt_nxt = bit_cnt_r + 5'h01;
          if (bit_cnt_r == WR_BITS - 5'h01) begin
            state_nxt = ST_PREAMBLE;
            case (reg_addr_r)
              REG_CTRL: begin
                ctrl_nxt = wr_word & 16'h7D80;
                restart_nxt = wr_word[CB_AN_RESTART];
                if (wr_word[CB_RESET]) begin
                  ctrl_nxt = CTRL_RESET_VAL;
                  adv_nxt = ADV_RESET_VAL;
                end
              end
              REG_ADV: adv_nxt = (wr_word & ADV_WRITE_MASK) |
                         (ADV_RESET_VAL & ~ADV_WRITE_MASK);
              default: begin
                mem_we = reg_addr_r[VEND_SEL_BIT];
                if (reg_addr_r == REG_VENDOR_MODE) begin
                  any_addr_nxt = wr_word[ANY_ADDR_BIT];
                end
              end
            endcase
          end
        end
        default: state_nxt = ST_PREAMBLE;
      endcase
    end
    if (restart_r) begin
      adv_live_nxt = adv_r;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_PREAMBLE;
      pre_cnt_r <= 6'h00;
      bit_cnt_r <= 5'h00;
      shift_r <= 16'h0000;
      reg_addr_r <= 5'h00;
      rd_word_r <= 16'h0000;
      oe_r <= 1'b0;
      ctrl_r <= CTRL_RESET_VAL;
      adv_r <= ADV_RESET_VAL;
      adv_live_r <= ADV_RESET_VAL;
      restart_r <= 1'b0;
      any_addr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pre_cnt_r <= pre_cnt_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shift_r <= shift_nxt;
      reg_addr_r <= reg_addr_nxt;
      rd_word_r <= rd_word_nxt;
      oe_r <= oe_nxt;
      ctrl_r <= ctrl_nxt;
      adv_r <= adv_nxt;
      adv_live_r <= adv_live_nxt;
      restart_r <= restart_nxt;
      any_addr_r <= any_addr_nxt;
    end
  end

  pms_regmem #(.WIDTH(16), .DEPTH(16), .AW(4)) u_vendor (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr_en(mem_we),
    .wr_addr(reg_addr_r[3:0]),
    .wr_data(wr_word),
    .rd_addr(reg_addr_r[3:0]),
    .rd_data(mem_rdata)
  );

  assign mdio_out = 1'b0;
  assign mdio_oe = oe_r;
  // Forced speed/duplex only matter to the core when negotiation is off
  assign ctrl = '{loopback: ctrl_r[CB_LOOPBACK], speed_100: ctrl_r[CB_SPEED],
                  an_enable: ctrl_r[CB_AN_EN], power_down: ctrl_r[CB_POWER_DOWN],
                  isolate: ctrl_r[CB_ISOLATE], full_duplex: ctrl_r[CB_DUPLEX],
                  collision_test: ctrl_r[CB_COL_TEST]};
  assign an_restart = restart_r;
  assign advertised = adv_live_r;
endmodule // pms_mgmt_port

// ==== tb/pms_mgmt_port_chk.sv ====
`timescale 1ns/1ps
module pms_mgmt_port_chk import pms_pkg::*; #(
  parameter int NUM_LEDS = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic mdc,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  input wire logic [4:0] station_address,
  input wire logic interrupt_mode,
  input wire logic interrupt_out_n,
  input wire logic shared_pin_oe,
  input wire logic transmit_side_bit,
  input wire logic [NUM_LEDS-1:0] led_state,
  input wire logic [NUM_LEDS-1:0] led_out,
  input wire pms_ctrl_s ctrl,
  input wire logic an_restart,
  input wire logic [15:0] advertised
);
  logic [3:0] up_r;
  logic [3:0] up_nxt;
  // Straps settle a few cycles after release, so stability is judged only once this saturates
  always_comb up_nxt = (up_r == 4'hF) ? up_r : up_r + 4'h1;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) up_r <= 4'h0;
    else up_r <= up_nxt;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_pulse; an_restart ##1 !an_restart; endsequence
  property p_drive_low; mdio_out == 1'b0; endproperty
  a_drive_low: assert property (p_drive_low) else $error("data line driven high");
  property p_oe_on_mdc; $changed(mdio_oe) |-> mdc; endproperty
  a_oe_on_mdc: assert property (p_oe_on_mdc) else $error("data moved off clock");
  property p_addr_hold; up_r == 4'hF |-> $stable(station_address); endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved");
  property p_mode_hold; up_r == 4'hF |-> $stable(interrupt_mode); endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("pin mode moved");
  property p_led; $past(rst_n) |-> led_out == $past(led_state ^ station_address[NUM_LEDS-1:0]);
  endproperty
  a_led: assert property (p_led) else $error("led polarity wrong");
  property p_int_n; !interrupt_out_n || shared_pin_oe |-> interrupt_mode; endproperty
  a_int_n: assert property (p_int_n) else $error("interrupt out of mode");
  property p_tx_bit; interrupt_mode |-> !transmit_side_bit; endproperty
  a_tx_bit: assert property (p_tx_bit) else $error("tx bit in interrupt mode");
  property p_pulse; an_restart |-> s_pulse; endproperty
  a_pulse: assert property (p_pulse) else $error("restart not a pulse");
  property p_adv; $changed(advertised) |-> $past(an_restart); endproperty
  a_adv: assert property (p_adv) else $error("advert moved without restart");
  property p_ctrl; $changed(ctrl) |-> mdc; endproperty
  a_ctrl: assert property (p_ctrl) else $error("control moved outside frame");
endmodule // pms_mgmt_port_chk
bind pms_mgmt_port pms_mgmt_port_chk #(.NUM_LEDS(NUM_LEDS)) u_chk (
  .mclk(mclk),
  .rst_n(rst_n),
  .mdc(mdc),
  .mdio_out(mdio_out),
  .mdio_oe(mdio_oe),
  .station_address(station_address),
  .interrupt_mode(interrupt_mode),
  .interrupt_out_n(interrupt_out_n),
  .shared_pin_oe(shared_pin_oe),
  .transmit_side_bit(transmit_side_bit),
  .led_state(led_state),
  .led_out(led_out),
  .ctrl(ctrl),
  .an_restart(an_restart),
  .advertised(advertised)
);

// ==== tb/pms_station_model.sv ====
`timescale 1ns/1ps
module pms_station_model (
  output logic mdc,
  output logic mdio_low,
  input wire logic mdio_wire
);
  localparam int HALF_NS = 200;
  initial begin
    mdc = 1'b0;
    mdio_low = 1'b0;
  end
  // A one is sent by releasing the line, so turnaround and read data need no special case
  task automatic send(input logic [64:0] v, input int n, output logic [15:0] rd);
    rd = 16'h0000;
    for (int i = n - 1; i >= 0; i--) begin
      mdio_low = !v[i];
      #HALF_NS mdc = 1'b1;
      rd = {rd[14:0], mdio_wire};
      #HALF_NS mdc = 1'b0;
    end
    // Idle gap keeps the next frame from driving the line in this same time step
    mdio_low = 1'b0;
    #HALF_NS;
  endtask
  task automatic write_reg(input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] d);
    logic [15:0] rd;
    send({1'h0, 32'hFFFFFFFF, 2'h1, 2'h1, phy, rg, 2'h2, d}, 64, rd);
  endtask
  // Two turnaround bits and sixteen data bits: the last sixteen samples are the word
  task automatic read_reg(input logic [4:0] phy, input logic [4:0] rg, output logic [15:0] d);
    send({32'hFFFFFFFF, 2'h1, 2'h2, phy, rg, 18'h3FFFF}, 64, d);
  endtask
endmodule // pms_station_model

// ==== tb/pms_mgmt_port_tb.sv ====
`timescale 1ns/1ps
module pms_mgmt_port_tb import pms_pkg::*;;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic fsel = 1'b1;
  logic int_req = 1'b0;
  logic tx_err = 1'b0;
  logic [4:0] addr_strap = 5'h1F;
  logic [3:0] led_state = 4'h5;
  pms_stat_s link_stat = 4'hA;
  logic mdc, mdio_low, mdio_out, mdio_oe, interrupt_mode, interrupt_out_n;
  logic shared_pin_oe, transmit_side_bit, an_restart;
  logic [4:0] station_address;
  logic [3:0] led_out;
  pms_ctrl_s ctrl;
  logic [15:0] advertised;
  logic [15:0] exp_t [7] = '{16'h3000, 16'h782D, 16'h1234, 16'h56A3, 16'h01E1, 16'hE7FF, 16'h0015};
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  wire mdio_wire = !((mdio_oe && !mdio_out) || mdio_low);
  always #5 mclk = ~mclk;
  pms_station_model u_smc (.mdc(mdc), .mdio_low(mdio_low), .mdio_wire(mdio_wire));
  pms_mgmt_port u_dut (.mclk(mclk), .rst_n(rst_n), .mdc(mdc), .mdio_in(mdio_wire),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .pin_function_select_strap(fsel),
    .station_address_strap(addr_strap), .station_address(station_address),
    .interrupt_mode(interrupt_mode), .interrupt_request(int_req),
    .interrupt_out_n(interrupt_out_n), .shared_pin_oe(shared_pin_oe),
    .transmit_error_in(tx_err), .transmit_side_bit(transmit_side_bit),
    .led_state(led_state), .led_out(led_out), .ctrl(ctrl), .an_restart(an_restart),
    .advertised(advertised), .link_stat(link_stat), .partner_ability(16'hFFFF),
    .expansion(5'h15));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd_chk(input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] exp);
    logic [15:0] d;
    u_smc.read_reg(phy, rg, d);
    chk($sformatf("reg%0d", rg), d, exp);
  endtask
  task automatic do_reset(input logic fs, input logic [4:0] a);
    rst_n = 1'b0;
    fsel = fs;
    addr_strap = a;
    repeat (8) @(negedge mclk);
    rst_n = 1'b1;
    repeat (8) @(negedge mclk);
    // Move the straps away: only the value at reset release may count
    fsel = !fs;
    addr_strap = ~a;
    repeat (4) @(negedge mclk);
  endtask
  task automatic pins(input logic [4:0] a, input logic m, input logic [3:0] led);
    chk("station_address", 16'(station_address), 16'(a));
    chk("interrupt_mode", 16'(interrupt_mode), 16'(m));
    chk("interrupt_out_n", 16'(interrupt_out_n), 16'(!m));
    chk("shared_pin_oe", 16'(shared_pin_oe), 16'(m));
    chk("transmit_side_bit", 16'(transmit_side_bit), 16'(!m));
    chk("led_out", 16'(led_out), 16'(led));
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 90000) begin
      n_errors++;
      print_verdict();
    end
  end
  initial begin
    @(negedge mclk);
    int_req = 1'b1;
    tx_err = 1'b1;
    do_reset(1'b1, 5'h0A);
    pins(5'h0A, 1'b1, 4'hF);
    for (int r = 0; r < 7; r++) begin
      rd_chk(5'h0A, 5'(r), exp_t[r]);
    end
    for (int r = 7; r < 16; r += 4) begin
      rd_chk(5'h0A, 5'(r), 16'hFFFF);
    end
    $display("test straps and reset values done");
    u_smc.write_reg(5'h0A, 5'h00, 16'h2100);
    u_smc.write_reg(5'h0B, 5'h00, 16'h3000);
    u_smc.write_reg(5'h0A, 5'h01, 16'h0000);
    rd_chk(5'h0A, 5'h00, 16'h2100);
    rd_chk(5'h0A, 5'h01, 16'h782D);
    chk("ctrl", 16'(ctrl), 16'h0022);
    $display("test forced mode done");
    u_smc.write_reg(5'h0A, 5'h04, 16'h0061);
    rd_chk(5'h0A, 5'h04, 16'h0061);
    chk("advertised", advertised, 16'h01E1);
    u_smc.write_reg(5'h0A, 5'h00, 16'h1200);
    chk("advertised", advertised, 16'h0061);
    rd_chk(5'h0A, 5'h00, 16'h1000);
    // Self-clearing reset bit restores both registers but must not re-advertise
    u_smc.write_reg(5'h0A, 5'h00, 16'h8000);
    chk("advertised", advertised, 16'h0061);
    chk("ctrl", 16'(ctrl), 16'h0030);
    rd_chk(5'h0A, 5'h00, 16'h3000);
    rd_chk(5'h0A, 5'h04, 16'h01E1);
    $display("test restart done");
    u_smc.write_reg(5'h0A, 5'h11, 16'h0008);
    u_smc.write_reg(5'h03, 5'h10, 16'h1234);
    rd_chk(5'h03, 5'h10, 16'h1234);
    $display("test any address done");
    do_reset(1'b0, 5'h1F);
    pins(5'h1F, 1'b0, 4'hA);
    u_smc.write_reg(5'h0A, 5'h10, 16'h5555);
    rd_chk(5'h1F, 5'h10, 16'h0000);
    $display("test second strap set done");
    print_verdict();
  end
endmodule // pms_mgmt_port_tb
